// ---- src/sis_pkg.sv ----
// Shared constants, register map and carrier types for the scan interrupt sequencer
package sis_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int N_PERIODIC = 8;
    localparam int N_EDGE = 6;
    localparam int N_SRC = N_PERIODIC + N_EDGE + 1;
    localparam int SRC_COMPARE = N_PERIODIC + N_EDGE;
    localparam int STEP_W = 16;
    localparam int LEN_W = 8;
    localparam int PERIOD_W = 16;
    localparam int WDT_W = 10;
    localparam int ERR_W = 8;
    localparam int EVT_W = 4;
    localparam logic [STEP_W-1:0] FIRST_STEP = 16'h0000;
    // ----------------------------------------
    // Timing: base tick of 2000 cycles, which is 10 us at a 5 ns clock
    // ----------------------------------------
    localparam int TICK_TIME_US = 10000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_PS;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LAST_STEP = 8'h04;
    localparam logic [7:0] OFS_ISR_LEN = 8'h08;
    localparam logic [7:0] OFS_SUB_LEN = 8'h0c;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h10;
    localparam logic [7:0] OFS_EDGE_SEL = 8'h14;
    localparam logic [7:0] OFS_WDT_TIME = 8'h18;
    localparam logic [7:0] OFS_STATE = 8'h1c;
    localparam logic [7:0] OFS_PENDING = 8'h20;
    localparam logic [7:0] OFS_ERROR_FLAG = 8'h24;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
    localparam logic [7:0] OFS_PERIOD0 = 8'h40;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [STEP_W-1:0] RST_LAST_STEP = 16'h00ff;
    localparam logic [LEN_W-1:0] RST_ISR_LEN = 8'h03;
    localparam logic [LEN_W-1:0] RST_SUB_LEN = 8'h03;
    localparam logic [PERIOD_W-1:0] RST_PERIOD = 16'h0064;
    localparam logic [WDT_W-1:0] RST_WDT_TIME = 10'h014;
    // ----------------------------------------
    // Error flag word fields
    // ----------------------------------------
    localparam int ERR_CPU_FATAL = 0;
    localparam int ERR_CPU_ORDINARY = 1;
    localparam int ERR_CONFIG = 2;
    localparam int ERR_NUMERIC = 3;
    localparam int ERR_WATCHDOG = 4;
    localparam int ERR_IO_LOST = 5;
    localparam int ERR_EXT_FATAL = 6;
    localparam int ERR_EXT_ORDINARY = 7;
    localparam logic [ERR_W-1:0] ERR_FATAL_MASK = 8'h75;
    // Interrupt status events
    localparam int EVT_SCAN_DONE = 0;
    localparam int EVT_ISR_START = 1;
    localparam int EVT_FATAL = 2;
    localparam int EVT_ORDINARY = 3;
    // Edge select codes
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_STOP = 4'b0001,
        ST_SCAN = 4'b0010,
        ST_INTR = 4'b0100,
        ST_SUB = 4'b1000
    } sis_state_t;
    typedef struct packed {
        logic cpu_fatal;
        logic cpu_ordinary;
        logic config_mismatch;
        logic numeric;
        logic io_lost;
        logic ext_fatal;
        logic ext_ordinary;
    } sis_err_t;
    typedef struct packed {
        sis_state_t state;
        logic [STEP_W-1:0] step;
        logic [3:0] active_src;
        logic scan_start;
        logic isr_start;
    } sis_status_t;
endpackage

// ---- src/sis_period_timer.sv ----
// Eight independent periodic interrupt timers counting base ticks
`timescale 1ns/1ps
module sis_period_timer
    import sis_pkg::*;
#(
    parameter int N = N_PERIODIC,
    parameter int W = PERIOD_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire logic run,
    input wire logic [N-1:0] enable,
    input wire logic [N*W-1:0] period,
    output logic [N-1:0] fire
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            logic [W-1:0] cnt;
            // Reload-and-fire counter; a zero period never fires
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt <= '0;
                    fire[i] <= 1'b0;
                end else begin
                    fire[i] <= 1'b0;
                    if (!run || !enable[i]) begin
                        cnt <= '0;
                    end else if (tick) begin
                        if (cnt + 1'b1 >= period[i*W +: W] && period[i*W +: W] != '0) begin
                            cnt <= '0;
                            fire[i] <= 1'b1;
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate
endmodule

// ---- src/sis_edge_detect.sv ----
// Per-input edge detection with rise, fall or both selection
`timescale 1ns/1ps
module sis_edge_detect
    import sis_pkg::*;
#(
    parameter int N = N_EDGE
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [N-1:0] din,
    input wire logic [2*N-1:0] sel,
    output logic [N-1:0] hit
);
    logic [N-1:0] prev;

    // Previous sample for edge comparison
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev <= '0;
        end else begin
            prev <= din;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_in
            // Zero selection code disables the input
            assign hit[i] = (sel[2*i] & din[i] & ~prev[i]) | (sel[2*i+1] & ~din[i] & prev[i]);
        end
    endgenerate
endmodule

// ---- src/sis_sequencer.sv ----
// Scan sequencer with interrupt pre-emption, subroutine calls and error handling
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
// Function
// - The main program steps once per scan from step 0 through the last step and then wraps.
// - An interrupt suspends the scan, runs its routine to the end and resumes at the same step.
// - Each periodic interrupt recurs at its own interval counted in 10 ms units; here the unit is the base tick of 2000 cycles, 10 us at a 5 ns clock.
// - Up to eight periodic interrupt sources exist, each with its own period.
// - Up to six external inputs can raise input-edge interrupts.
// - Each input-edge interrupt detects rising, falling or both edges as selected.
// - The counter-compare routine starts whenever the counter drives its match signal.
// - A subroutine runs only when the main program calls it.
// - Every error is either fatal and halts, or ordinary and only warns.
// - Any error is recorded in the flags before the stop-or-continue decision.
// - A CPU defect forces the stopped state while an ordinary CPU fault lets running go on.
// - A configuration mismatch is flagged and forces the stopped state.
// - The current error state is kept in one readable error flag word.
// - Numeric errors only set flags, while watchdog expiry or loss of I/O control stop the device.
module sis_sequencer
    import sis_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [N_EDGE-1:0] input_edge_interrupt,
    input wire logic counter_compare_interrupt,
    input wire logic call_req,
    input wire sis_err_t err_in,
    output sis_status_t status,
    output logic irq
);
    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    logic run;
    logic [STEP_W-1:0] last_step;
    logic [LEN_W-1:0] isr_len;
    logic [LEN_W-1:0] sub_len;
    logic [N_SRC-1:0] int_enable;
    logic [2*N_EDGE-1:0] edge_sel;
    logic [WDT_W-1:0] wdt_time;
    logic [N_PERIODIC*PERIOD_W-1:0] period;
    logic [ERR_W-1:0] error_code_flag;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_mask;
    logic [N_SRC-1:0] pending;
    sis_state_t state;
    logic [STEP_W-1:0] step;
    logic [LEN_W-1:0] run_cnt;
    logic [3:0] active_src;
    logic [31:0] tick_cnt;
    logic tick;
    logic [WDT_W-1:0] wdt_cnt;
    logic scan_done;
    logic isr_start;

    // Bus address phase capture
    logic wr_pend;
    logic [7:0] wr_addr;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Lowest set index wins; index is the priority number
    function automatic logic [4:0] pick_lowest(input logic [N_SRC-1:0] req);
        logic [4:0] r;
        r = '0;
        for (int k = N_SRC - 1; k >= 0; k--) begin
            if (req[k]) begin
                r = {1'b1, 4'(k)};
            end
        end
        return r;
    endfunction

    // Write-one-to-clear with set winning over clear
    function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
        return (cur & ~clr) | set;
    endfunction

    // ----------------------------------------
    // Interrupt sources
    // ----------------------------------------
    logic [N_PERIODIC-1:0] periodic_fire;
    logic [N_EDGE-1:0] edge_hit;
    logic [N_SRC-1:0] raised;
    logic [4:0] pick;

    sis_period_timer #(
        .N(N_PERIODIC),
        .W(PERIOD_W)
    ) u_period (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .run(state != ST_STOP),
        .enable(int_enable[N_PERIODIC-1:0]),
        .period(period),
        .fire(periodic_fire)
    );

    sis_edge_detect #(
        .N(N_EDGE)
    ) u_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(input_edge_interrupt),
        .sel(edge_sel),
        .hit(edge_hit)
    );

    // Source vector: periodic, then input edges, then counter compare
    assign raised = {counter_compare_interrupt, edge_hit & int_enable[N_PERIODIC +: N_EDGE],
                     periodic_fire};
    assign pick = pick_lowest(pending);

    // Base tick generator, shared by timers and the watchdog
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 32'(TICK_COUNT - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_COUNT - 1)) ? '0 : tick_cnt + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // Errors
    // ----------------------------------------
    logic [ERR_W-1:0] err_set;
    logic wdt_expire;
    logic fatal_now;

    assign wdt_expire = (state != ST_STOP) && (wdt_time != '0) && (wdt_cnt >= wdt_time);
    assign err_set = {err_in.ext_ordinary, err_in.ext_fatal, err_in.io_lost, wdt_expire,
                      err_in.numeric, err_in.config_mismatch, err_in.cpu_ordinary,
                      err_in.cpu_fatal};
    assign fatal_now = |(err_set & ERR_FATAL_MASK);

    // Watchdog restarts when the scan wraps from the last step to step 0, not at a subroutine return, and is held at zero when stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_cnt <= '0;
        end else if (state == ST_STOP || scan_done) begin
            wdt_cnt <= '0;
        end else if (tick && !wdt_expire) begin
            wdt_cnt <= wdt_cnt + 1'b1;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic at_last;
    logic run_done;
    assign at_last = (step == last_step);
    assign run_done = (run_cnt == isr_len && state == ST_INTR) || (run_cnt == sub_len && state == ST_SUB);
    assign scan_done = (state == ST_SCAN) && !pick[4] && !call_req && at_last;
    assign isr_start = (state == ST_SCAN) && pick[4] && !fatal_now && run;

    // State: fatal errors and a cleared run bit override everything
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_STOP;
        end else if (fatal_now || !run) begin
            state <= ST_STOP;
        end else begin
            case (state)
                ST_STOP: begin
                    if ((error_code_flag & ERR_FATAL_MASK) == '0) begin
                        state <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (pick[4]) begin
                        state <= ST_INTR;
                    end else if (call_req) begin
                        state <= ST_SUB;
                    end
                end
                ST_INTR: begin
                    if (run_done) begin
                        state <= ST_SCAN;
                    end
                end
                ST_SUB: begin
                    if (run_done) begin
                        state <= ST_SCAN;
                    end
                end
                default: begin
                    state <= ST_STOP;
                end
            endcase
        end
    end

    // Step pointer: held while a routine runs; the scan resumes at the same step after an interrupt and at the next step after a subroutine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step <= FIRST_STEP;
        end else if (state == ST_STOP) begin
            step <= FIRST_STEP;
        end else if (!fatal_now && run) begin
            if ((state == ST_SCAN && !pick[4] && !call_req) || (state == ST_SUB && run_done)) begin
                step <= at_last ? FIRST_STEP : step + 1'b1;
            end
        end
    end

    // Routine length counter for interrupt routines and subroutines
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_cnt <= '0;
        end else if (state == ST_INTR || state == ST_SUB) begin
            run_cnt <= run_done ? '0 : run_cnt + 1'b1;
        end else begin
            run_cnt <= '0;
        end
    end

    // Source being served; pending requests wait for the routine to finish
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_src <= '0;
            pending <= '0;
        end else begin
            if (isr_start) begin
                active_src <= pick[3:0];
            end
            if (state == ST_STOP) begin
                pending <= '0;
            end else if (isr_start) begin
                pending <= (pending & ~(N_SRC'(1) << pick[3:0])) | raised;
            end else begin
                pending <= pending | raised;
            end
        end
    end

    // Status outputs come from flip-flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '{state: ST_STOP, step: FIRST_STEP, active_src: 4'h0, scan_start: 1'b0, isr_start: 1'b0};
        end else begin
            status.state <= state;
            status.step <= step;
            status.active_src <= active_src;
            status.scan_start <= scan_done;
            status.isr_start <= isr_start;
        end
    end

    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    logic addr_ok;
    logic [7:0] a;
    logic wr_now;
    logic [31:0] rd_mux;
    logic [ERR_W-1:0] err_clr;
    logic [EVT_W-1:0] irq_clr;
    logic [EVT_W-1:0] evt_set;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && htrans[1] && hready;
    assign a = haddr[7:0];
    assign wr_now = wr_pend;
    assign err_clr = (wr_now && wr_addr == OFS_ERROR_FLAG) ? hwdata[ERR_W-1:0] : '0;
    assign irq_clr = (wr_now && wr_addr == OFS_IRQ_STATUS) ? hwdata[EVT_W-1:0] : '0;
    assign evt_set = {|(err_set & ~ERR_FATAL_MASK), fatal_now, isr_start, scan_done};

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= a;
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        case (a)
            OFS_CTRL: rd_mux[0] = run;
            OFS_LAST_STEP: rd_mux[STEP_W-1:0] = last_step;
            OFS_ISR_LEN: rd_mux[LEN_W-1:0] = isr_len;
            OFS_SUB_LEN: rd_mux[LEN_W-1:0] = sub_len;
            OFS_INT_ENABLE: rd_mux[N_SRC-1:0] = int_enable;
            OFS_EDGE_SEL: rd_mux[2*N_EDGE-1:0] = edge_sel;
            OFS_WDT_TIME: rd_mux[WDT_W-1:0] = wdt_time;
            OFS_STATE: rd_mux = {4'h0, active_src, 4'h0, state, step};
            OFS_PENDING: rd_mux[N_SRC-1:0] = pending;
            OFS_ERROR_FLAG: rd_mux[ERR_W-1:0] = error_code_flag;
            OFS_IRQ_STATUS: rd_mux[EVT_W-1:0] = irq_status;
            OFS_IRQ_MASK: rd_mux[EVT_W-1:0] = irq_mask;
            default: begin
                if (a >= OFS_PERIOD0 && a < OFS_PERIOD0 + 8'(4 * N_PERIODIC) && a[1:0] == 2'h0) begin
                    rd_mux[PERIOD_W-1:0] = period[3'(a[4:2]) * PERIOD_W +: PERIOD_W];
                end
            end
        endcase
    end

    // Read data registered at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // Configuration writes during the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run <= 1'b0;
            last_step <= RST_LAST_STEP;
            isr_len <= RST_ISR_LEN;
            sub_len <= RST_SUB_LEN;
            int_enable <= '0;
            edge_sel <= '0;
            wdt_time <= RST_WDT_TIME;
            irq_mask <= '0;
            period <= {N_PERIODIC{RST_PERIOD}};
        end else if (wr_now) begin
            case (wr_addr)
                OFS_CTRL: run <= hwdata[0];
                OFS_LAST_STEP: last_step <= hwdata[STEP_W-1:0];
                OFS_ISR_LEN: isr_len <= hwdata[LEN_W-1:0];
                OFS_SUB_LEN: sub_len <= hwdata[LEN_W-1:0];
                OFS_INT_ENABLE: int_enable <= hwdata[N_SRC-1:0];
                OFS_EDGE_SEL: edge_sel <= hwdata[2*N_EDGE-1:0];
                OFS_WDT_TIME: wdt_time <= hwdata[WDT_W-1:0];
                OFS_IRQ_MASK: irq_mask <= hwdata[EVT_W-1:0];
                default: begin
                    if (wr_addr >= OFS_PERIOD0 && wr_addr < OFS_PERIOD0 + 8'(4 * N_PERIODIC)
                        && wr_addr[1:0] == 2'h0) begin
                        period[3'(wr_addr[4:2]) * PERIOD_W +: PERIOD_W] <= hwdata[PERIOD_W-1:0];
                    end
                end
            endcase
        end
    end

    // Sticky error flags and interrupt status; a new event beats a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            error_code_flag <= '0;
            irq_status <= '0;
        end else begin
            error_code_flag <= sticky(error_code_flag, err_set, err_clr);
            irq_status <= EVT_W'(sticky({4'h0, irq_status}, {4'h0, evt_set}, {4'h0, irq_clr}));
        end
    end

    // Level interrupt while any unmasked event is held
    assign irq = |(irq_status & irq_mask);
endmodule

// ---- verif/sis_checker.sv ----
// Port assertions for the scan interrupt sequencer
`timescale 1ns/1ps
module sis_checker
    import sis_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic call_req,
    input wire logic counter_compare_interrupt,
    input wire sis_err_t err_in,
    input wire sis_status_t status
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Fatal classes on the error inputs
    logic fat;
    sis_state_t st;
    assign fat = err_in.cpu_fatal | err_in.config_mismatch | err_in.io_lost | err_in.ext_fatal;
    assign st = status.state;
    sequence s_scan2;
        st == ST_SCAN ##1 st == ST_SCAN;
    endsequence
    sequence s_intr4;
        (st == ST_INTR)[*4];
    endsequence
    chk_step_advance: assert property (s_scan2 |->
        status.step == $past(status.step) + 16'h1 || status.step == FIRST_STEP) else $error("step skipped");
    chk_intr_hold: assert property (st == ST_INTR ##1 st == ST_INTR |-> $stable(status.step))
        else $error("step moved in routine");
    chk_intr_len: assert property ($rose(st == ST_INTR) |-> s_intr4) else $error("routine cut short");
    chk_call_only: assert property ($rose(st == ST_SUB) |-> $past(call_req, 2))
        else $error("subroutine without call");
    chk_fatal_stop: assert property (fat |-> ##[1:3] st == ST_STOP) else $error("fatal error kept running");
    chk_ordinary_run: assert property (st == ST_SCAN && !fat && err_in != '0 |=> (st != ST_STOP)[*3])
        else $error("ordinary error stopped");
    chk_stop_home: assert property (st == ST_STOP ##1 st == ST_STOP |-> status.step == FIRST_STEP)
        else $error("stopped away from step zero");
    chk_compare_start: assert property ($rose(counter_compare_interrupt) && st == ST_SCAN |->
        ##[1:16] status.isr_start) else $error("compare routine not started");
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
endmodule

bind sis_sequencer sis_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .call_req(call_req), .counter_compare_interrupt(counter_compare_interrupt),
    .err_in(err_in), .status(status));

// ---- verif/sis_io_model.sv ----
// Behavioural model of the input points and the high-speed counter
`timescale 1ns/1ps
module sis_io_model
    import sis_pkg::*;
(
    input wire logic hclk,
    output logic [N_EDGE-1:0] pins,
    output logic match
);
    // Idle levels at time zero
    initial begin
        pins = '0;
        match = 1'b0;
    end
    // Levels change just after an edge; match lasts one cycle only
    task automatic drive(input logic [N_EDGE-1:0] p, input logic m);
        @(posedge hclk);
        pins <= p;
        match <= m;
        @(posedge hclk);
        match <= 1'b0;
    endtask
endmodule

// ---- verif/scan_interrupt_sequencer_tb_top.sv ----
// Self-checking testbench for the scan interrupt sequencer
`timescale 1ns/1ps
module scan_interrupt_sequencer_tb_top import sis_pkg::*;;
    localparam logic [7:0] RA [6] = '{OFS_LAST_STEP, OFS_ISR_LEN, OFS_PERIOD0, OFS_WDT_TIME, OFS_STATE, 8'h30};
    localparam logic [31:0] RV [6] = '{32'hff, 32'h3, 32'h64, 32'h14, 32'h10000, 32'h0};
    localparam int EC [4] = '{1, 1, 2, 0};
    localparam int FL [7] = '{7, 6, 5, 3, 2, 1, 0};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, call_req = 1'b0, hreadyout, hresp, irq, cmp, src_due = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [N_EDGE-1:0] pins;
    sis_err_t err_in = '0;
    sis_status_t status;
    int errors = 0, check_count = 0, cyc = 0, isr_cnt = 0, scan_t = 0, scan_gap = 0, i, n;
    int tq[$];
    logic [3:0] srcq[$];

    always #2.5 hclk = ~hclk;
    // Short base tick keeps timer runs brief
    sis_sequencer #(.TICK_COUNT(10)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .input_edge_interrupt(pins),
        .counter_compare_interrupt(cmp), .call_req(call_req), .err_in(err_in), .status(status), .irq(irq));
    sis_io_model pm (.hclk(hclk), .pins(pins), .match(cmp));

    // Event log; the served source shows one cycle after the start pulse
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        src_due <= (status.isr_start === 1'b1);
        if (src_due)
            srcq.push_back(status.active_src);
        if (status.isr_start === 1'b1) begin
            isr_cnt <= isr_cnt + 1;
            tq.push_back(cyc);
        end
        if (status.scan_start === 1'b1) begin
            scan_gap <= cyc - scan_t;
            scan_t <= cyc;
        end
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        results();
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One single AHB-Lite transfer; read data lands in q
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge hclk);
    endtask
    // One-cycle call pulse, then a bounded wait for the subroutine
    task automatic call();
        @(posedge hclk);
        call_req <= 1'b1;
        @(posedge hclk);
        call_req <= 1'b0;
        for (n = 0; n < 6 && status.state !== ST_SUB; n++) @(posedge hclk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        wt(6);
        hresetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            bus(0, RA[i], 0);
            chk("reset value", q, RV[i]);
        end
        call();
        chk("call while stopped", status.state, ST_STOP);
        bus(1, OFS_WDT_TIME, 0);
        bus(1, OFS_LAST_STEP, 7);
        bus(1, OFS_SUB_LEN, 10);
        bus(1, OFS_IRQ_MASK, 32'h4);
        bus(1, OFS_CTRL, 1);
        wt(40);
        chk("scan length", scan_gap, 8);
        call();
        chk("call in scan", status.state, ST_SUB);
        $display("test scan and call finished");
        // Timers 0 and 7 with different periods
        for (i = 0; i < 8; i += 7) begin
            bus(1, OFS_PERIOD0 + 8'(4 * i), 2 + i);
            bus(1, OFS_INT_ENABLE, 1 << i);
            tq.delete();
            wt(40 * (2 + i));
            chk("period", tq[2] - tq[1], 10 * (2 + i));
            chk("period source", srcq[$], i);
        end
        bus(1, OFS_INT_ENABLE, 32'h3f00);
        bus(1, OFS_EDGE_SEL, 32'h39);
        // Inputs 0 to 3 select rise, fall, both and off
        for (i = 0; i < 4; i++) begin
            n = isr_cnt;
            pm.drive(6'(1 << i), 1'b0);
            wt(20);
            pm.drive(6'h0, 1'b0);
            wt(20);
            chk("edge count", isr_cnt - n, EC[i]);
        end
        pm.drive(6'h0, 1'b1);
        wt(20);
        chk("compare source", srcq[$], SRC_COMPARE);
        // Both raised during a long subroutine, so both wait together
        srcq.delete();
        call();
        pm.drive(6'h1, 1'b1);
        wt(40);
        pm.drive(6'h0, 1'b0);
        chk("first served", srcq[0], 4'h8);
        chk("second served", srcq[1], SRC_COMPARE);
        bus(1, OFS_INT_ENABLE, 0);
        $display("test interrupts finished");
        for (i = 0; i < 7; i++) begin
            @(posedge hclk);
            err_in <= sis_err_t'(7'h1 << i);
            @(posedge hclk);
            err_in <= '0;
            wt(6);
            bus(0, OFS_ERROR_FLAG, 0);
            chk("error flag", q, 32'h1 << FL[i]);
            bus(0, OFS_STATE, 0);
            chk("error state", q[19:16], ERR_FATAL_MASK[FL[i]] ? ST_STOP : ST_SCAN);
            chk("fatal irq", irq, ERR_FATAL_MASK[FL[i]]);
            bus(1, OFS_ERROR_FLAG, 32'hff);
            bus(1, OFS_IRQ_STATUS, 32'hf);
            wt(4);
            chk("irq cleared", irq, 0);
        end
        // Long scan against a two-tick watchdog
        bus(1, OFS_WDT_TIME, 2);
        bus(1, OFS_LAST_STEP, 32'hff);
        wt(60);
        bus(0, OFS_ERROR_FLAG, 0);
        chk("watchdog flag", q, 32'h10);
        chk("watchdog stop", status.state, ST_STOP);
        $display("test errors finished");
        results();
    end
endmodule
